/* File: rcs_pkg.sv */
// Shared codes, field positions and timing for the card command interpreter.
// Assumes one card-side interpreter running on the core clock.
package rcs_pkg;
    // Link cycles between command end bit and response start
    localparam int NCR_CYCLES = 5;
    localparam logic [2:0] NCR_CNT = 3'(NCR_CYCLES);
    // Frame lengths in bits
    localparam int SHORT_BITS = 48;
    localparam int LONG_BITS = 136;
    localparam int PAD_BITS = LONG_BITS - SHORT_BITS;
    localparam logic [7:0] SHORT_LEN = 8'(SHORT_BITS);
    localparam logic [7:0] LONG_LEN = 8'(LONG_BITS);
    localparam logic [5:0] RX_LAST = 6'(SHORT_BITS - 1);
    // Command indices
    localparam logic [5:0] CMD_SW_RESET = 6'h00;
    localparam logic [5:0] CMD_OP_COND = 6'h01;
    localparam logic [5:0] CMD_ID_ALL = 6'h02;
    localparam logic [5:0] CMD_SET_ADDR = 6'h03;
    localparam logic [5:0] CMD_SET_DRV = 6'h04;
    localparam logic [5:0] CMD_SELECT = 6'h07;
    localparam logic [5:0] CMD_GET_SPEC = 6'h09;
    localparam logic [5:0] CMD_GET_IDENT = 6'h0a;
    localparam logic [5:0] CMD_RD_STREAM = 6'h0b;
    localparam logic [5:0] CMD_STOP = 6'h0c;
    localparam logic [5:0] CMD_GET_STATUS = 6'h0d;
    localparam logic [5:0] CMD_GO_INACT = 6'h0f;
    localparam logic [5:0] CMD_BLK_LEN = 6'h10;
    localparam logic [5:0] CMD_RD_ONE = 6'h11;
    localparam logic [5:0] CMD_RD_MANY = 6'h12;
    // Status word bit positions
    localparam int SB_RANGE = 31;
    localparam int SB_LEN = 29;
    localparam int SB_CRC = 23;
    localparam int SB_ILLEGAL = 22;
    localparam int SB_STATE = 9;
    // Fixed frame contents
    localparam logic [31:0] VR_FIELD = 32'h00ffc000;
    localparam logic [5:0] RSV_HEAD = 6'h3f;
    localparam logic [6:0] RSV_TAIL = 7'h7f;
    localparam logic [47:0] VR_FRAME = {2'h0, RSV_HEAD, VR_FIELD, RSV_TAIL, 1'h1};
    localparam logic [15:0] ADDR_DEFAULT = 16'h0001;
    localparam logic [15:0] ADDR_NONE = 16'h0000;
    localparam logic [6:0] CRC7_POLY = 7'h09;
    // Argument limits
    localparam logic [31:0] MEM_BYTES = 32'h0010_0000;
    localparam logic [31:0] BLK_LEN_MAX = 32'h0000_0200;

    typedef enum logic [2:0] {
        ST_IDLE, ST_READY, ST_IDENT, ST_STBY, ST_TRAN, ST_DATA, ST_INA
    } rcs_state_e;
    typedef enum logic [2:0] {
        RSP_NONE, RSP_SHORT, RSP_IDENT, RSP_SPEC, RSP_VR
    } rcs_rsp_e;
    typedef struct packed {
        logic [5:0] idx;
        logic [31:0] arg;
    } rcs_cmd_s;
endpackage

/* File: rcs_card.sv */
// Card-side command interpreter: state machine, status word and responses.
// Assumes the host drives LINK_CLK and the command line; the bench resolves
// the open-drain command wire from CMD_OE and CMD_OUT.
`timescale 1ns/1ns
module rcs_card
    import rcs_pkg::*;
#(
    parameter logic [127:0] IDENT_VALUE = 128'h1111_2222_3333_4444_5555_6666_7777_8888, // Arbitrary
    parameter logic [127:0] SPEC_VALUE = 128'h0a0b_0c0d_0e0f_1011_1213_1415_1617_1819
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic LINK_CLK,
    input wire logic CMD_IN,
    input wire logic XFER_LEN_ERR,
    output logic CMD_OUT,
    output logic CMD_OE
);

    function automatic logic [6:0] crc7(input logic [39:0] d);
        logic [6:0] c;
        logic fb;
        c = '0;
        for (int i = 39; i >= 0; i--) begin
            fb = d[i] ^ c[6];
            c = {c[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Link synchronisers
    logic [1:0] clk_sync;
    logic [1:0] cmd_sync;
    logic clk_prev;
    logic rise;
    logic line;

    // Link clock and line each pass two flops before use
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            clk_sync <= '0;
            cmd_sync <= 2'h3;
            clk_prev <= 1'b0;
        end else begin
            clk_sync <= {clk_sync[0], LINK_CLK};
            cmd_sync <= {cmd_sync[0], CMD_IN};
            clk_prev <= clk_sync[1];
        end
    end

    assign rise = clk_sync[1] & ~clk_prev;
    assign line = cmd_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // Command receiver
    logic rx_on;
    logic rx_done;
    logic [5:0] rx_cnt;
    logic [47:0] rx_sh;
    logic tx_busy;

    // Listening is off while we own the line, so own bits never loop back
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_on <= 1'b0;
            rx_done <= 1'b0;
            rx_cnt <= '0;
            rx_sh <= '0;
        end else begin
            rx_done <= 1'b0;
            if (rise && !tx_busy) begin
                if (rx_on) begin
                    rx_sh <= {rx_sh[46:0], line};
                    rx_cnt <= rx_cnt + 6'h01;
                    if (rx_cnt == RX_LAST) begin
                        rx_on <= 1'b0;
                        rx_done <= 1'b1;
                    end
                end else if (!line) begin
                    rx_on <= 1'b1;
                    rx_cnt <= 6'h01;
                    rx_sh <= {rx_sh[46:0], line};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode
    rcs_cmd_s cmd;
    rcs_state_e state;
    rcs_state_e next_state;
    rcs_rsp_e rsp;
    logic [15:0] relative_address;
    logic host_frame;
    logic crc_ok;
    logic addr_hit;
    logic acc;
    logic ev_crc;
    logic bad;
    logic oor;
    logic blen;
    logic busy_state;

    assign cmd = {rx_sh[45:40], rx_sh[39:8]};
    // Frames with a card transmitter bit belong to another card
    assign host_frame = rx_sh[46];
    assign crc_ok = (crc7(rx_sh[47:8]) == rx_sh[7:1]) && rx_sh[0];
    assign addr_hit = cmd.arg[31:16] == relative_address;
    // Inactive card takes nothing, not even reset
    assign acc = rx_done & host_frame & crc_ok & (state != ST_INA);
    assign ev_crc = rx_done & host_frame & ~crc_ok;
    assign busy_state = (state == ST_STBY) || (state == ST_TRAN) || (state == ST_DATA);

    // Transition table; unlisted pairs keep the state
    always_comb begin
        next_state = state;
        rsp = RSP_NONE;
        bad = 1'b0;
        oor = 1'b0;
        blen = 1'b0;
        case (cmd.idx)
            CMD_SW_RESET: next_state = ST_IDLE;
            CMD_OP_COND: begin
                if (state == ST_IDLE) begin
                    next_state = ST_READY;
                    rsp = RSP_VR;
                end else bad = 1'b1;
            end
            CMD_ID_ALL: begin
                if (state == ST_READY) rsp = RSP_IDENT;
                else bad = 1'b1;
            end
            CMD_SET_ADDR: begin
                if (state == ST_IDENT) begin
                    next_state = ST_STBY;
                    rsp = RSP_SHORT;
                end else bad = 1'b1;
            end
            CMD_SET_DRV: bad = state != ST_STBY;
            CMD_SELECT: begin
                if (addr_hit && cmd.arg[31:16] != ADDR_NONE) begin
                    if (state == ST_STBY) begin
                        next_state = ST_TRAN;
                        rsp = RSP_SHORT;
                    end else bad = 1'b1;
                end else if (state == ST_TRAN || state == ST_DATA) begin
                    next_state = ST_STBY;
                end
            end
            CMD_GET_SPEC, CMD_GET_IDENT: begin
                if (addr_hit) begin
                    if (state != ST_STBY) bad = 1'b1;
                    else if (cmd.idx == CMD_GET_SPEC) rsp = RSP_SPEC;
                    else rsp = RSP_IDENT;
                end
            end
            CMD_STOP: begin
                if (state == ST_DATA) begin
                    next_state = ST_TRAN;
                    rsp = RSP_SHORT;
                end else bad = 1'b1;
            end
            CMD_GET_STATUS: begin
                if (addr_hit) begin
                    if (busy_state) rsp = RSP_SHORT;
                    else bad = 1'b1;
                end
            end
            CMD_GO_INACT: begin
                if (addr_hit && busy_state) next_state = ST_INA;
            end
            CMD_RD_STREAM, CMD_RD_ONE, CMD_RD_MANY: begin
                if (state == ST_TRAN) begin
                    oor = cmd.arg >= MEM_BYTES;
                    // A read past the end does not start
                    if (!oor) next_state = ST_DATA;
                    rsp = RSP_SHORT;
                end else bad = 1'b1;
            end
            CMD_BLK_LEN: begin
                if (state == ST_TRAN) begin
                    blen = (cmd.arg == 32'h0) || (cmd.arg > BLK_LEN_MAX);
                    rsp = RSP_SHORT;
                end else bad = 1'b1;
            end
            default: next_state = state;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Status word
    logic f_len;
    logic f_crc;
    logic f_ill;
    logic [31:0] status;
    logic [39:0] short_head;
    logic [135:0] load;

    // All other bits stay zero
    always_comb begin
        status = '0;
        status[SB_RANGE] = oor;
        status[SB_LEN] = f_len | blen | XFER_LEN_ERR;
        status[SB_CRC] = f_crc;
        status[SB_ILLEGAL] = f_ill;
        status[SB_STATE +: 4] = 4'(next_state);
    end

    // Flags are cleared once shown; a same-cycle event is shown, not lost
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            f_len <= 1'b0;
            f_crc <= 1'b0;
            f_ill <= 1'b0;
        end else if (acc && rsp == RSP_SHORT) begin
            f_len <= 1'b0;
            f_crc <= 1'b0;
            f_ill <= 1'b0;
        end else begin
            if (XFER_LEN_ERR) f_len <= 1'b1;
            if (ev_crc) f_crc <= 1'b1;
            if (acc && bad) f_ill <= 1'b1;
        end
    end

    assign short_head = {2'h0, cmd.idx, status};

    // Frame images, left aligned, MSB first
    always_comb begin
        case (rsp)
            RSP_IDENT: load = {2'h0, RSV_HEAD, IDENT_VALUE[127:1], 1'b1};
            RSP_SPEC: load = {2'h0, RSV_HEAD, SPEC_VALUE[127:1], 1'b1};
            RSP_VR: load = {VR_FRAME, {PAD_BITS{1'b0}}};
            default: load = {short_head, crc7(short_head), 1'b1, {PAD_BITS{1'b0}}};
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State and address
    logic fin;
    logic mism;
    logic lost;
    logic tx_arb;

    // Bad CRC and unknown commands leave the state alone
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= ST_IDLE;
        end else if (acc) begin
            state <= next_state;
        end else if (fin && tx_arb && !lost && !mism) begin
            state <= ST_IDENT;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            relative_address <= ADDR_DEFAULT;
        end else if (acc && cmd.idx == CMD_SW_RESET) begin
            relative_address <= ADDR_DEFAULT;
        end else if (acc && cmd.idx == CMD_SET_ADDR && state == ST_IDENT) begin
            relative_address <= cmd.arg[31:16];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Response transmitter
    logic tx_act;
    logic tx_od;
    logic tx_bit;
    logic [2:0] tx_wait;
    logic [7:0] tx_left;
    logic [135:0] tx_sh;

    // Line is sampled before our next bit goes out, so it holds our bit
    assign mism = tx_act & tx_arb & (line != tx_bit);
    assign fin = rise & tx_busy & (tx_wait == 3'h0) & (tx_left == 8'h00);

    // A losing card stays muted to the frame end so the winner is not disturbed
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_busy <= 1'b0;
            tx_act <= 1'b0;
            tx_od <= 1'b0;
            tx_arb <= 1'b0;
            tx_bit <= 1'b1;
            lost <= 1'b0;
            tx_wait <= '0;
            tx_left <= '0;
            tx_sh <= '0;
            CMD_OUT <= 1'b0;
            CMD_OE <= 1'b0;
        end else if (acc && rsp != RSP_NONE) begin
            tx_busy <= 1'b1;
            tx_act <= 1'b0;
            lost <= 1'b0;
            tx_wait <= NCR_CNT;
            tx_od <= (state == ST_IDLE) || (state == ST_READY) || (state == ST_IDENT);
            tx_arb <= (rsp == RSP_IDENT) && (state == ST_READY);
            tx_sh <= load;
            tx_left <= (rsp == RSP_IDENT || rsp == RSP_SPEC) ? LONG_LEN : SHORT_LEN;
        end else if (rise && tx_busy) begin
            if (tx_wait != 3'h0) begin
                tx_wait <= tx_wait - 3'h1;
            end else if (tx_left == 8'h00) begin
                tx_busy <= 1'b0;
                tx_act <= 1'b0;
                CMD_OE <= 1'b0;
                CMD_OUT <= 1'b0;
            end else begin
                tx_bit <= tx_sh[135];
                tx_sh <= {tx_sh[134:0], 1'b0};
                tx_left <= tx_left - 8'h01;
                tx_act <= 1'b1;
                if (mism || lost) begin
                    lost <= 1'b1;
                    CMD_OE <= 1'b0;
                end else begin
                    CMD_OE <= tx_od ? ~tx_sh[135] : 1'b1;
                    CMD_OUT <= tx_od ? 1'b0 : tx_sh[135];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [3:0] gap;

    // Link edges seen between command end and first response bit
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) gap <= '0;
        else if (acc) gap <= '0;
        else if (rise && tx_busy && !tx_act && gap != 4'hf) gap <= gap + 4'h1;
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_acc(logic [5:0] i);
        acc && cmd.idx == i;
    endsequence
    sequence s_first_bit;
        rise && tx_busy && !tx_act && tx_wait == 3'h0 && tx_left != 8'h00;
    endsequence

    idle_ready_a: assert property (
        s_acc(CMD_OP_COND) ##0 state == ST_IDLE |=> state == ST_READY && tx_wait == NCR_CNT)
        else $error("idle did not move to ready");
    ina_hold_a: assert property (
        rx_done && state == ST_INA |=> state == ST_INA && !tx_busy)
        else $error("inactive card reacted");
    stop_tran_a: assert property (
        s_acc(CMD_STOP) ##0 state == ST_DATA |=> state == ST_TRAN)
        else $error("stop did not return to tran");
    select_a: assert property (
        s_acc(CMD_SELECT) ##0 (state == ST_STBY && addr_hit && relative_address != ADDR_NONE)
        |=> state == ST_TRAN)
        else $error("select failed");
    deselect_a: assert property (
        s_acc(CMD_SELECT) ##0 (!addr_hit && state == ST_TRAN) |=> state == ST_STBY)
        else $error("deselect failed");
    crc_hold_a: assert property (
        ev_crc |=> $stable(state) && f_crc && !tx_busy)
        else $error("bad frame changed state");
    resp_gap_a: assert property (
        s_first_bit |-> gap == 4'(NCR_CYCLES))
        else $error("response gap wrong");
    end_bit_a: assert property (
        fin && !tx_od |-> CMD_OUT && CMD_OE)
        else $error("end bit not high");
    arb_stop_a: assert property (
        rise && tx_busy && mism |=> !CMD_OE && lost ##1 !CMD_OE)
        else $error("kept driving after loss");
    addr_reset_a: assert property (
        s_acc(CMD_SW_RESET) |=> relative_address == ADDR_DEFAULT && state == ST_IDLE)
        else $error("reset did not restore address");

endmodule

/* File: rcs_host.sv */
// Host model for the card command interpreter: makes the link clock,
// drives commands on the command line and captures the card's replies.
// Assumes the bench resolves the open-drain command wire with a pull-up.
`timescale 1ns/1ns
module rcs_host (
    output logic link_clk,
    output logic host_oe,
    output logic host_bit,
    input wire logic cmd_wire
);
    ////////////////////////////////////////////////////////////////////////////////
    // Clock idles low between frames; it only runs during transfers
    initial begin
        link_clk = 1'b0;
        host_oe = 1'b0;
        host_bit = 1'b1;
    end

    // CRC7, x7+x3+1, fed MSB first
    function automatic logic [6:0] crc7(input logic [39:0] d);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        for (int i = 39; i >= 0; i--) begin
            fb = d[i] ^ c[6];
            c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
        end
        return c;
    endfunction

    // One link period; wire sampled just before the rise, long settled by then
    task automatic pulse(output logic s);
        #160;
        s = cmd_wire;
        link_clk = 1'b1;
        #160;
        link_clk = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // One command, then listen; clash pulls the line low during one reply bit,
    // the way a competing card would
    task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input bit bad,
        input int len, input int clash, output logic [135:0] rsp, output int gap);
        logic [47:0] f;
        logic s;
        f = {2'b01, idx, arg, crc7({2'b01, idx, arg}) ^ {6'h00, bad}, 1'b1};
        rsp = '0;
        gap = 0;
        host_oe = 1'b1;
        for (int i = 47; i >= 0; i--) begin
            host_bit = f[i];
            pulse(s);
        end
        host_oe = 1'b0;
        host_bit = 1'b1;
        // Bounded wait for a start bit; no reply leaves gap at 0
        for (int n = 1; n <= 12 && gap == 0; n++) begin
            pulse(s);
            if (s === 1'b0) gap = n;
        end
        for (int k = 1; k < len && gap != 0; k++) begin
            host_oe = (k == clash);
            host_bit = (k != clash);
            pulse(s);
            rsp[len - 1 - k] = s;
        end
        host_oe = 1'b0;
        host_bit = 1'b1;
        // Recovery clocks before the next command
        repeat (8) pulse(s);
    endtask
endmodule

/* File: rom_card_state_response_tb.sv */
// Bench for the card command interpreter: identification, transfer states,
// status flags and resets, each reply checked bit for bit.
// Assumes the host model and the card share one pulled-up command wire.
`timescale 1ns/1ns
module rom_card_state_response_tb;
    import rcs_pkg::*;
    // Register contents, arbitrary
    localparam logic [127:0] IDV = 128'h9c3a_5e71_0f24_b8d6_4a19_e207_c5f3_6b8d;
    localparam logic [127:0] SPV = 128'h2d7e_c041_93b5_6af8_1e0c_d752_a4b9_3f61;
    localparam logic [31:0] ADDR = 32'h0005_0000;
    localparam logic [31:0] OTHER = 32'h0009_0000;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic xfer_len_err = 1'b0;
    logic link_clk, host_oe, host_bit, card_out, card_oe;
    wire logic cmd_wire;
    logic [135:0] rsp;
    logic [5:0] reads [3] = '{CMD_RD_STREAM, CMD_RD_ONE, CMD_RD_MANY};
    int gap;
    int fails = 0;
    int tests_run = 0;

    ////////////////////////////////////////////////////////////////////////////////
    always #20 core_clk = ~core_clk;
    // Open-drain wire: any driver low wins, else pulled up
    assign cmd_wire = ((host_oe && !host_bit) || (card_oe && !card_out)) ? 1'b0 : 1'b1;

    rcs_card #(.IDENT_VALUE(IDV), .SPEC_VALUE(SPV)) rcs_card_i (
        .CORE_CLK(core_clk), .RST_N(rst_n), .LINK_CLK(link_clk), .CMD_IN(cmd_wire),
        .XFER_LEN_ERR(xfer_len_err), .CMD_OUT(card_out), .CMD_OE(card_oe));
    rcs_host rcs_host_i (.link_clk(link_clk), .host_oe(host_oe), .host_bit(host_bit),
        .cmd_wire(cmd_wire));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [135:0] got, input logic [135:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Status word with the state field filled in
    function automatic logic [31:0] sw(input logic [3:0] st, input logic [31:0] flags);
        return flags | ({28'h0, st} << 9);
    endfunction

    task automatic send(input logic [5:0] idx, input logic [31:0] arg, input int len = 48,
        input bit bad = 1'b0, input int clash = -1);
        rcs_host_i.xfer(idx, arg, bad, len, clash, rsp, gap);
    endtask

    // Expected short reply built from index, status and its own CRC
    task automatic short_rsp(input logic [5:0] idx, input logic [31:0] arg, input logic [31:0] st);
        send(idx, arg);
        check(rsp, {88'h0, 2'b00, idx, st, rcs_host_i.crc7({2'b00, idx, st}), 1'b1},
            "short reply");
    endtask

    task automatic no_rsp(input logic [5:0] idx, input logic [31:0] arg, input bit bad = 1'b0);
        send(idx, arg, 48, bad);
        check(136'(gap), 136'h0, "unexpected reply");
    endtask

    task automatic long_rsp(input logic [5:0] idx, input logic [31:0] arg, input logic [127:0] r);
        send(idx, arg, 136);
        check(rsp, {2'b00, 6'h3f, r[127:1], 1'b1}, "long reply");
    endtask

    task automatic vr_rsp();
        send(CMD_OP_COND, 32'h0);
        check(rsp, 136'h3f_00ff_c000_ff, "voltage reply");
        check(136'(gap), 136'(NCR_CYCLES + 2), "reply gap");
    endtask

    // Winning arbitration, then address assignment
    task automatic win();
        long_rsp(CMD_ID_ALL, 32'h0, IDV);
        short_rsp(CMD_SET_ADDR, ADDR, sw(4'h3, 32'h0));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: a hang counts as a failure
    initial begin
        #3_000_000;
        fails++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        @(negedge core_clk) rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        vr_rsp();
        send(CMD_ID_ALL, 32'h0, 136, 1'b0, 2);
        check(rsp, {3'b000, {133{1'b1}}}, "lost arbitration");
        win();
        $display("test identification done");
        long_rsp(CMD_GET_SPEC, ADDR, SPV);
        long_rsp(CMD_GET_IDENT, ADDR, IDV);
        no_rsp(CMD_GET_STATUS, OTHER);
        no_rsp(CMD_GET_STATUS, ADDR, 1'b1);
        short_rsp(CMD_GET_STATUS, ADDR, sw(4'h3, 32'h0080_0000));
        no_rsp(CMD_STOP, ADDR);
        short_rsp(CMD_GET_STATUS, ADDR, sw(4'h3, 32'h0040_0000));
        short_rsp(CMD_GET_STATUS, ADDR, sw(4'h3, 32'h0));
        no_rsp(CMD_SET_DRV, 32'h0);
        $display("test standby done");
        short_rsp(CMD_SELECT, ADDR, sw(4'h4, 32'h0));
        short_rsp(CMD_BLK_LEN, 32'h0, sw(4'h4, 32'h2000_0000));
        short_rsp(CMD_BLK_LEN, BLK_LEN_MAX, sw(4'h4, 32'h0));
        short_rsp(CMD_RD_ONE, MEM_BYTES, sw(4'h4, 32'h8000_0000));
        short_rsp(CMD_GET_STATUS, ADDR, sw(4'h4, 32'h0));
        no_rsp(6'h05, ADDR);
        short_rsp(CMD_GET_STATUS, ADDR, sw(4'h4, 32'h0));
        foreach (reads[i]) begin
            short_rsp(reads[i], MEM_BYTES - 1, sw(4'h5, 32'h0));
            short_rsp(CMD_STOP, 32'h0, sw(4'h4, 32'h0));
        end
        @(negedge core_clk) xfer_len_err = 1'b1;
        @(negedge core_clk) xfer_len_err = 1'b0;
        short_rsp(CMD_GET_STATUS, ADDR, sw(4'h4, 32'h2000_0000));
        no_rsp(CMD_SELECT, 32'h0);
        short_rsp(CMD_GET_STATUS, ADDR, sw(4'h3, 32'h0));
        short_rsp(CMD_SELECT, ADDR, sw(4'h4, 32'h0));
        short_rsp(CMD_RD_MANY, 32'h0, sw(4'h5, 32'h0));
        no_rsp(CMD_SELECT, OTHER);
        short_rsp(CMD_GET_STATUS, ADDR, sw(4'h3, 32'h0));
        $display("test transfer done");
        no_rsp(CMD_SW_RESET, 32'h0);
        vr_rsp();
        win();
        no_rsp(CMD_GO_INACT, ADDR);
        no_rsp(CMD_SW_RESET, 32'h0);
        no_rsp(CMD_OP_COND, 32'h0);
        // Only a hardware reset brings an inactive card back
        @(negedge core_clk) rst_n = 1'b0;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        vr_rsp();
        $display("test reset done");
        complete_run();
    end
endmodule
